// ==== hdl/dgcp_params.svh ====
// constants of the dual group complementary pwm block
`ifndef DGCP_PARAMS_SVH
`define DGCP_PARAMS_SVH
`define DGCP_CNT_W         16
`define DGCP_DEAD_RST      16'h0050
`define DGCP_HALF_RST      16'h07d0
`define DGCP_UPPER_RST     16'h0820
`define DGCP_DUTY_RST      16'h03e8
`define DGCP_PERIOD_CYC    16'h0f9f
`define DGCP_READ_PERIOD   5'h19
`define DGCP_AGREE_TARGET  2'h3
`define DGCP_SW_IDLE       1'b1
`define DGCP_GROUP_RST     1'b0
`endif

// ==== hdl/dgcp_pkg.sv ====
// shared types of the dual group complementary pwm block
`include "dgcp_params.svh"
package dgcp_pkg;
   // counting direction of a triangle counter
   typedef enum logic {DGCP_UP = 1'b0, DGCP_DOWN = 1'b1} dgcp_dir_type;
   // one level per phase output, index 0..2 is pwm output 1..3
   typedef struct packed {
      logic [2:0] pos;
      logic [2:0] neg;
   } dgcp_phase_type;
   // duty values of the three outputs
   typedef struct packed {
      logic [`DGCP_CNT_W-1:0] duty3;
      logic [`DGCP_CNT_W-1:0] duty2;
      logic [`DGCP_CNT_W-1:0] duty1;
   } dgcp_duty_type;
   // dead time and the two turning limits
   typedef struct packed {
      logic [`DGCP_CNT_W-1:0] dead;
      logic [`DGCP_CNT_W-1:0] half;
      logic [`DGCP_CNT_W-1:0] upper;
   } dgcp_limit_type;
endpackage : dgcp_pkg

// ==== hdl/dgcp_updown.sv ====
// triangle up/down counter with turning limits
`timescale 1ns/1ps
`include "dgcp_params.svh"
module dgcp_updown #(
   parameter logic [`DGCP_CNT_W-1:0] START = 16'h0000
) (
   input  wire logic                   clock_i,   // counter clock
   input  wire logic                   sys_rst_i, // async reset, high
   input  wire logic [`DGCP_CNT_W-1:0] lo_i,      // trough value
   input  wire logic [`DGCP_CNT_W-1:0] hi_i,      // crest value
   output logic [`DGCP_CNT_W-1:0]      count_o,   // current count
   output dgcp_pkg::dgcp_dir_type      dir_o,     // current direction
   output logic                        crest_o,   // turning at top
   output logic                        trough_o   // turning at bottom
);
   ////////////////////////////////////////////////////////////////
   logic [`DGCP_CNT_W-1:0] count_q; // counter value
   dgcp_pkg::dgcp_dir_type dir_q;   // direction flop

   // turning points, tolerant of a limit moved past the count
   assign crest_o  = (dir_q == dgcp_pkg::DGCP_UP) && (count_q >= hi_i);
   assign trough_o = (dir_q == dgcp_pkg::DGCP_DOWN) && (count_q <= lo_i);
   assign count_o  = count_q;
   assign dir_o    = dir_q;

   ////////////////////////////////////////////////////////////////
   // one step per clock, no clear path at all
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         count_q <= START;
      end else if (crest_o) begin
         count_q <= count_q - 16'h0001;
      end else if (trough_o) begin
         count_q <= count_q + 16'h0001;
      end else begin
         case (dir_q)
            dgcp_pkg::DGCP_UP:   count_q <= count_q + 16'h0001;
            dgcp_pkg::DGCP_DOWN: count_q <= count_q - 16'h0001;
            default:             count_q <= count_q;
         endcase
      end
   end

   // direction reverses only at the limits
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dir_q <= dgcp_pkg::DGCP_UP;
      end else if (crest_o) begin
         dir_q <= dgcp_pkg::DGCP_DOWN;
      end else if (trough_o) begin
         dir_q <= dgcp_pkg::DGCP_UP;
      end
   end

   ////////////////////////////////////////////////////////////////
   a_crest_turn: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      crest_o |=> (dir_q == dgcp_pkg::DGCP_DOWN) && (count_q == $past(count_q) - 16'h0001))
      else $error("counter did not turn down at crest");
   a_step_one: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      1'b1 |=> ((count_q - $past(count_q)) == 16'h0001)
               || (($past(count_q) - count_q) == 16'h0001))
      else $error("counter moved by other than one");
endmodule : dgcp_updown

// ==== hdl/dgcp_pwm.sv ====
// three phase complementary pwm with two switchable output groups
`timescale 1ns/1ps
`include "dgcp_params.svh"
module dgcp_pwm (
   input  wire logic                     clock_i,     // peripheral clock
   input  wire logic                     sys_rst_i,   // async reset, high
   input  wire dgcp_pkg::dgcp_duty_type  duty_i,      // new duty values
   input  wire logic                     duty_wr_i,   // load duty buffers
   input  wire dgcp_pkg::dgcp_limit_type limit_i,     // new dead time, limits
   input  wire logic                     limit_wr_i,  // load limit buffers
   input  wire logic                     switch_i,    // push switch level
   input  wire dgcp_pkg::dgcp_phase_type grp0_in_i,   // group 0 pin levels
   input  wire dgcp_pkg::dgcp_phase_type grp1_in_i,   // group 1 pin levels
   output dgcp_pkg::dgcp_phase_type      grp0_out_o,  // group 0 pin data
   output dgcp_pkg::dgcp_phase_type      grp0_oe_n_o, // group 0 enable, low
   output dgcp_pkg::dgcp_phase_type      grp1_out_o,  // group 1 pin data
   output dgcp_pkg::dgcp_phase_type      grp1_oe_n_o, // group 1 enable, low
   output dgcp_pkg::dgcp_phase_type      idle_in_o,   // idle group levels
   output logic                          sync_out_o,  // carrier toggle
   output logic                          carrier_irq_o, // compare pulse
   output logic                          switch_decided_o, // decided flag
   output logic                          active_group_o    // driving group
);
   ////////////////////////////////////////////////////////////////
   // counters
   logic [`DGCP_CNT_W-1:0] timer_count_a; // channel a count
   logic [`DGCP_CNT_W-1:0] timer_count_b; // channel b count
   dgcp_pkg::dgcp_dir_type dir_a;         // channel a direction
   dgcp_pkg::dgcp_dir_type dir_b;         // channel b direction
   logic                   crest_a;       // channel a at top
   logic                   trough_a;      // channel a at bottom
   logic                   crest_b;       // channel b at top
   logic                   trough_b;      // channel b at bottom
   logic                   transfer;      // buffer copy point

   // limit registers and their buffers
   logic [`DGCP_CNT_W-1:0] dead_time_offset_reg_q;    // dead time
   logic [`DGCP_CNT_W-1:0] half_cycle_limit_reg_q;    // b crest
   logic [`DGCP_CNT_W-1:0] half_cycle_limit_buffer_q; // b crest buffer
   logic [`DGCP_CNT_W-1:0] ch_a_upper_limit_reg_q;    // a crest
   logic [`DGCP_CNT_W-1:0] ch_a_limit_buffer_q;       // a crest buffer

   // duty registers, buffers and phase levels per output
   logic [`DGCP_CNT_W-1:0] duty_in [3];    // duty input per phase
   logic [`DGCP_CNT_W-1:0] duty_reg_q [3]; // active duty
   logic [`DGCP_CNT_W-1:0] duty_buf_q [3]; // buffered duty
   logic                   pos_q [3];      // positive phase level
   logic                   neg_q [3];      // negative phase level
   dgcp_pkg::dgcp_phase_type phase;        // levels as a struct

   // carrier side outputs
   logic sync_q;  // toggle output
   logic irq_q;   // compare interrupt pulse

   // switch handling
   logic [4:0] switch_read_period_counter_q; // irqs since last sample
   logic       sample;                       // switch read strobe
   logic       last_q;                       // previous sample
   logic [1:0] switch_agree_counter_q;       // agreeing samples
   logic [1:0] agree_d;                      // next agree count
   logic       fixed_q;                      // accepted level
   logic       fall;                         // debounced falling edge
   logic       switch_decided_flag_q;        // change pending
   logic       group_chg;                    // group swap this cycle
   logic       group_q;                      // driving group
   dgcp_pkg::dgcp_phase_type idle_in_q;      // idle group levels

   ////////////////////////////////////////////////////////////////
   // channel a runs from dead time up to its upper limit
   dgcp_updown #(
      .START (`DGCP_DEAD_RST)
   ) timer_channel_a (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .lo_i      (dead_time_offset_reg_q),
      .hi_i      (ch_a_upper_limit_reg_q),
      .count_o   (timer_count_a),
      .dir_o     (dir_a),
      .crest_o   (crest_a),
      .trough_o  (trough_a)
   );

   // channel b runs from zero up to the half cycle limit
   dgcp_updown #(
      .START (16'h0000)
   ) timer_channel_b (
      .clock_i   (clock_i),
      .sys_rst_i (sys_rst_i),
      .lo_i      (16'h0000),
      .hi_i      (half_cycle_limit_reg_q),
      .count_o   (timer_count_b),
      .dir_o     (dir_b),
      .crest_o   (crest_b),
      .trough_o  (trough_b)
   );

   // copy point at both crest and trough
   assign transfer = crest_b | trough_b;

   ////////////////////////////////////////////////////////////////
   // buffer writes; dead time takes effect at once
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         dead_time_offset_reg_q    <= `DGCP_DEAD_RST;
         half_cycle_limit_buffer_q <= `DGCP_HALF_RST;
         ch_a_limit_buffer_q       <= `DGCP_UPPER_RST;
      end else if (limit_wr_i) begin
         dead_time_offset_reg_q    <= limit_i.dead;
         half_cycle_limit_buffer_q <= limit_i.half;
         ch_a_limit_buffer_q       <= limit_i.upper;
      end
   end

   // active limits follow their buffers only at the copy point
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         half_cycle_limit_reg_q <= `DGCP_HALF_RST;
         ch_a_upper_limit_reg_q <= `DGCP_UPPER_RST;
      end else if (transfer) begin
         half_cycle_limit_reg_q <= half_cycle_limit_buffer_q;
         ch_a_upper_limit_reg_q <= ch_a_limit_buffer_q;
      end
   end

   ////////////////////////////////////////////////////////////////
   // duty fields in phase order
   assign duty_in[0] = duty_i.duty1;
   assign duty_in[1] = duty_i.duty2;
   assign duty_in[2] = duty_i.duty3;

   // per output: duty buffer, active duty and both phase levels
   // positive edges use channel b, negative edges channel a, so each
   // pair is kept apart by the dead time offset
   for (genvar i = 0; i < 3; i++) begin : g_phase
      // buffer written by software on every duty_wr_i pulse, at any point of the carrier
      always_ff @(posedge clock_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            duty_buf_q[i] <= `DGCP_DUTY_RST;
         end else if (duty_wr_i) begin
            duty_buf_q[i] <= duty_in[i];
         end
      end

      // active duty only changes at the copy point
      always_ff @(posedge clock_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            duty_reg_q[i] <= `DGCP_DUTY_RST;
         end else if (transfer) begin
            duty_reg_q[i] <= duty_buf_q[i];
         end
      end

      // positive phase: low on up match, high on down match
      always_ff @(posedge clock_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            pos_q[i] <= 1'b1;
         end else if (timer_count_b == duty_reg_q[i]) begin
            pos_q[i] <= (dir_b == dgcp_pkg::DGCP_DOWN);
         end
      end

      // negative phase: high on up match, low on down match
      always_ff @(posedge clock_i or posedge sys_rst_i) begin
         if (sys_rst_i) begin
            neg_q[i] <= 1'b1;
         end else if (timer_count_a == duty_reg_q[i]) begin
            neg_q[i] <= (dir_a == dgcp_pkg::DGCP_UP);
         end
      end

      // gather into the pin struct
      assign phase.pos[i] = pos_q[i];
      assign phase.neg[i] = neg_q[i];
   end

   ////////////////////////////////////////////////////////////////
   // toggle at each turn of channel a, one square wave per carrier
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sync_q <= 1'b0;
      end else if (crest_a | trough_a) begin
         sync_q <= ~sync_q;
      end
   end

   // compare match on the upper limit, once per triangle
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= crest_a;
      end
   end

   ////////////////////////////////////////////////////////////////
   // read strobe on every 25th interrupt
   assign sample = irq_q
                   && (switch_read_period_counter_q
                       == 5'(`DGCP_READ_PERIOD - 5'h01));

   // interrupt counter wraps at the read period
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         switch_read_period_counter_q <= 5'h00;
      end else if (sample) begin
         switch_read_period_counter_q <= 5'h00;
      end else if (irq_q) begin
         switch_read_period_counter_q <= switch_read_period_counter_q + 5'h01;
      end
   end

   // count agreeing samples, saturating at the target
   always_comb begin
      if (switch_i != last_q) begin
         agree_d = 2'h1; // mismatch restarts the run
      end else if (switch_agree_counter_q == `DGCP_AGREE_TARGET) begin
         agree_d = `DGCP_AGREE_TARGET; // hold at target
      end else begin
         agree_d = switch_agree_counter_q + 2'h1;
      end
   end

   // debounce state, updated on read strobes only
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         last_q                 <= `DGCP_SW_IDLE;
         switch_agree_counter_q <= 2'h0;
         fixed_q                <= `DGCP_SW_IDLE;
      end else if (sample) begin
         last_q                 <= switch_i;
         switch_agree_counter_q <= agree_d;
         if (agree_d == `DGCP_AGREE_TARGET) begin
            fixed_q <= switch_i;
         end
      end
   end

   // accepted level goes from high to low
   assign fall = sample && (agree_d == `DGCP_AGREE_TARGET)
                 && fixed_q && !switch_i;

   // a pending flag swaps the group on the next edge
   assign group_chg = switch_decided_flag_q;

   // new edge wins over the clear in the same cycle
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         switch_decided_flag_q <= 1'b0;
      end else begin
         switch_decided_flag_q <= fall | (switch_decided_flag_q & ~group_chg);
      end
   end

   // driving group alternates on each decided edge
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         group_q <= `DGCP_GROUP_RST;
      end else if (group_chg) begin
         group_q <= ~group_q;
      end
   end

   // idle group pins read back as general inputs
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         idle_in_q <= '1;
      end else begin
         idle_in_q <= group_q ? grp0_in_i : grp1_in_i;
      end
   end

   ////////////////////////////////////////////////////////////////
   // pins: both groups carry the waveform, one is enabled
   assign grp0_out_o       = phase;
   assign grp1_out_o       = phase;
   assign grp0_oe_n_o      = {6{group_q}};
   assign grp1_oe_n_o      = {6{~group_q}};
   assign idle_in_o        = idle_in_q;
   assign sync_out_o       = sync_q;
   assign carrier_irq_o    = irq_q;
   assign switch_decided_o = switch_decided_flag_q;
   assign active_group_o   = group_q;

   ////////////////////////////////////////////////////////////////
   // helper: cycles between interrupts, voided by a limit or duty write
   logic [`DGCP_CNT_W-1:0] gap_q;   // cycles since last interrupt
   logic                   seen_q;  // one interrupt already seen
   logic                   moved_q; // limits or duties written inside the period
   always_ff @(posedge clock_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         gap_q   <= 16'h0000;
         seen_q  <= 1'b0;
         moved_q <= 1'b0;
      end else begin
         gap_q   <= irq_q ? 16'h0000 : gap_q + 16'h0001;
         seen_q  <= seen_q | irq_q;
         moved_q <= (limit_wr_i | duty_wr_i) | (moved_q & ~irq_q);
      end
   end

   a_carrier_period: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (irq_q && seen_q && !moved_q && (half_cycle_limit_reg_q == `DGCP_HALF_RST)
       && (ch_a_upper_limit_reg_q == `DGCP_UPPER_RST)
       && (dead_time_offset_reg_q == `DGCP_DEAD_RST)) |-> (gap_q == `DGCP_PERIOD_CYC))
      else $error("interrupt spacing differs from carrier period");
   a_crest_align: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (crest_a && !moved_q && !seen_q) |-> (crest_b && (timer_count_b == `DGCP_HALF_RST)))
      else $error("channel crests not aligned");
   a_dead_offset: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (!moved_q && !seen_q) |-> (timer_count_a == timer_count_b + dead_time_offset_reg_q))
      else $error("channel offset is not the dead time");
   a_pos_up_low: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      ((timer_count_b == duty_reg_q[0]) && (dir_b == dgcp_pkg::DGCP_UP))
      |=> !grp0_out_o.pos[0])
      else $error("positive phase not low after up match");
   a_neg_down_low: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      ((timer_count_a == duty_reg_q[1]) && (dir_a == dgcp_pkg::DGCP_DOWN))
      |=> !grp0_out_o.neg[1])
      else $error("negative phase not low after down match");
   a_no_overlap: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (!moved_q && !seen_q) |-> ((phase.pos | phase.neg) == 3'h7))
      else $error("both phases of a pair active");
   a_sync_toggle: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (crest_a || trough_a) |=> (sync_out_o != $past(sync_out_o)))
      else $error("sync output missed a toggle");
   a_copy_point: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      transfer |=> (duty_reg_q[2] == $past(duty_buf_q[2])))
      else $error("duty not copied at turning point");
   a_duty_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      !transfer |=> $stable(duty_reg_q[0]))
      else $error("active duty changed outside copy point");
   a_fall_flag: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      $rose(switch_decided_o) |-> ($past(fixed_q) && !fixed_q && $past(sample)))
      else $error("flag set without debounced falling edge");
   a_group_swap: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      switch_decided_o |=> (active_group_o != $past(active_group_o))
                           && (switch_decided_o == $past(fall)))
      else $error("group swap or flag clear wrong");
   a_one_group: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      (grp0_oe_n_o == ~grp1_oe_n_o) && ((grp0_oe_n_o == 6'h00) || (grp0_oe_n_o == 6'h3f)))
      else $error("output groups not exclusive");
   a_read_spacing: assert property (@(posedge clock_i) disable iff (sys_rst_i)
      sample |-> (irq_q && (switch_read_period_counter_q == 5'h18)))
      else $error("switch read off the 25th interrupt");
endmodule : dgcp_pwm

// ==== testbench/dgcp_drv_model.sv ====
// gate driver and push switch model standing at the pins of the pwm block
`timescale 1ns/1ps
module dgcp_drv_model (
   input  wire logic                     clock_i,  // peripheral clock
   input  wire dgcp_pkg::dgcp_phase_type out0_i,   // group 0 data
   input  wire dgcp_pkg::dgcp_phase_type oe0_n_i,  // group 0 enable, low
   input  wire dgcp_pkg::dgcp_phase_type out1_i,   // group 1 data
   input  wire dgcp_pkg::dgcp_phase_type oe1_n_i,  // group 1 enable, low
   input  wire logic                     press_i,  // operator holds the switch
   output dgcp_pkg::dgcp_phase_type      pin0_o,   // group 0 wire level
   output dgcp_pkg::dgcp_phase_type      pin1_o,   // group 1 wire level
   output logic                          switch_o  // switch level, low pressed
);
   dgcp_pkg::dgcp_phase_type last0_q = '0; // previous group 0 wire levels
   dgcp_pkg::dgcp_phase_type last1_q = '0; // previous group 1 wire levels
   ////////////////////////////////////////////////////////////////////////////
   // released pins have no keeper, so they flip instead of holding a value
   assign pin0_o = (~oe0_n_i & out0_i) | (oe0_n_i & ~last0_q);
   assign pin1_o = (~oe1_n_i & out1_i) | (oe1_n_i & ~last1_q);
   // remember last wire levels
   always_ff @(posedge clock_i) begin
      last0_q <= pin0_o;
      last1_q <= pin1_o;
   end
   // bounce free switch, held across many read periods
   assign switch_o = ~press_i;
endmodule : dgcp_drv_model

// ==== testbench/dgcp_pwm_tb.sv ====
// self-checking bench of the dual group complementary pwm block
`timescale 1ns/1ps
module dgcp_pwm_tb;
   logic                     clock_i, sys_rst_i, duty_wr_i, limit_wr_i, press, sw;
   dgcp_pkg::dgcp_duty_type  duty_i;             // duty values
   dgcp_pkg::dgcp_limit_type limit_i;            // dead time and limits
   dgcp_pkg::dgcp_phase_type pin0, pin1, out0, out1, oe0, oe1, idle;
   logic                     sync_o, irq_o, dec_o, grp_o; // single outputs
   int                       error_cnt, comparisons, cycles;
   dgcp_pwm DUT (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .duty_i(duty_i),
      .duty_wr_i(duty_wr_i), .limit_i(limit_i), .limit_wr_i(limit_wr_i), .switch_i(sw),
      .grp0_in_i(pin0), .grp1_in_i(pin1), .grp0_out_o(out0), .grp0_oe_n_o(oe0),
      .grp1_out_o(out1), .grp1_oe_n_o(oe1), .idle_in_o(idle), .sync_out_o(sync_o),
      .carrier_irq_o(irq_o), .switch_decided_o(dec_o), .active_group_o(grp_o));
   dgcp_drv_model u_drv (.clock_i(clock_i), .out0_i(out0), .oe0_n_i(oe0), .out1_i(out1),
      .oe1_n_i(oe1), .press_i(press), .pin0_o(pin0), .pin1_o(pin1), .switch_o(sw));
   ////////////////////////////////////////////////////////////////////////////
   // step one cycle, inputs move just after the edge
   task automatic tick;
      @(posedge clock_i);
      #1;
   endtask : tick
   // compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // counts and verdict
   task automatic tally_and_finish;
      $display("comparisons %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   ////////////////////////////////////////////////////////////////////////////
   // 7100 cycles, two interrupts, with documented counts: irq times, edges, dead gap
   task automatic t_default;
      int fi, si, pf, pr, nf;
      fi = 0; si = 0; pf = 0; pr = 0; nf = 0;
      for (int c = 1; c <= 7100; c++) begin
         tick;
         if (irq_o === 1'b1 && fi == 0) fi = c;
         if (irq_o === 1'b1 && fi != 0 && c > fi && si == 0) si = c;
         if (out0.pos[0] === 1'b0 && pf == 0) pf = c;
         if (pf != 0 && out0.pos[0] === 1'b1 && pr == 0) pr = c;
         if (out0.neg[0] === 1'b0 && nf == 0) nf = c;
      end
      chk("first irq", fi, 2001);
      chk("second irq", si, 6001);
      chk("pos fall", pf, 1001);
      chk("pos width", pr - pf, 2000);
      chk("dead gap", nf - pr, 80);
   endtask : t_default
   // short carrier, new duties through buffers, one full period measured
   task automatic t_short;
      int n, tg, pl, nh;
      logic s;
      duty_i = {3{16'h005a}};
      limit_i = {16'h0050, 16'h0064, 16'h00b4};
      duty_wr_i = 1'b1;
      limit_wr_i = 1'b1;
      tick;
      duty_wr_i = 1'b0;
      limit_wr_i = 1'b0;
      n = 0;
      while (irq_o !== 1'b1 && n < 2000) begin tick; n++; end
      chk("copy at trough", n, 1000);
      n = 0; tg = 0; pl = 0; nh = 0; s = sync_o;
      do begin
         tick;
         n++;
         if (sync_o !== s) tg++;
         s = sync_o;
         if (out0.pos === 3'h0) pl++;
         if (out0.neg === 3'h7) nh++;
      end while (irq_o !== 1'b1 && n < 1000);
      chk("period", n, 200);
      chk("sync toggles", tg, 2);
      chk("pos active", pl, 20);
      chk("neg high", nh, 180);
   endtask : t_short
   // hold the switch down until one decided pulse swaps the groups
   task automatic t_press(input logic g);
      int n, c;
      dgcp_pkg::dgcp_phase_type s; // idle levels expected next cycle
      press = 1'b1;
      n = 0; c = 0;
      while (dec_o !== 1'b1 && c < 20000) begin tick; c++; if (irq_o === 1'b1) n++; end
      chk("reads to decide", (n >= 51 && n <= 75), 1);
      tick;
      chk("flag one cycle", dec_o, 1'b0);
      chk("group", {grp_o, oe0, oe1}, {g, g ? 12'hfc0 : 12'h03f});
      tick;
      s = ~idle;
      tick;
      chk("idle flips", idle, s);
   endtask : t_press
   // release is a rising edge and must not switch
   task automatic t_release;
      int d;
      press = 1'b0;
      d = 0;
      repeat (20000) begin tick; if (dec_o !== 1'b0) d++; end
      chk("no rise event", d, 0);
   endtask : t_release
   ////////////////////////////////////////////////////////////////////////////
   // free running clock, 20 ns
   initial begin
      clock_i = 1'b0;
      forever #10 clock_i = ~clock_i;
   end
   // hang guard
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 90000) begin error_cnt++; tally_and_finish; end
   end
   // main sequence
   initial begin
      sys_rst_i = 1'b1; duty_wr_i = 1'b0; limit_wr_i = 1'b0; press = 1'b0;
      duty_i = '0; limit_i = '0; error_cnt = 0; comparisons = 0; cycles = 0;
      repeat (4) @(posedge clock_i);
      #1;
      chk("rst pins", {out0, out1, oe0, oe1}, 24'hfff03f);
      chk("rst flags", {idle, sync_o, irq_o, dec_o, grp_o}, 10'h3f0);
      sys_rst_i = 1'b0;
      t_default;
      t_short;
      t_press(1'b1);
      t_release;
      t_press(1'b0);
      tally_and_finish;
   end
endmodule : dgcp_pwm_tb
